// ==== src/cbi_pkg.sv ====
// Package of the CPU system bus interface: register map, field positions,
// reset values, bus-cycle timing counts and the cycle sequencer states.
// Assumes a 100 MHz SYS_CLK; all counts are in SYS_CLK cycles.
package cbi_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] CBI_OFS_ADDR  = 8'h00; // Cycle address, 16 bits
  localparam logic [7:0] CBI_OFS_WDATA = 8'h04; // Write data, 8 bits
  localparam logic [7:0] CBI_OFS_CMD   = 8'h08; // Cycle command
  localparam logic [7:0] CBI_OFS_CYC   = 8'h0C; // Cycle state, read only
  localparam logic [7:0] CBI_OFS_PSTAT = 8'h10; // Processor status
  localparam logic [7:0] CBI_OFS_RDATA = 8'h14; // Captured read data
  localparam logic [7:0] CBI_OFS_EXT   = 8'h18; // Extension register
  localparam logic [7:0] CBI_OFS_SHIFT = 8'h1C; // Serial shift trigger

  // Command register fields
  localparam int CBI_CMD_GO_BIT   = 0;
  localparam int CBI_CMD_READ_BIT = 1;
  localparam int CBI_CMD_EXT_LSB  = 2;  // Three extra status bits, 4:2

  // Cycle state register fields
  localparam int CBI_CYC_BUSY_BIT  = 0;
  localparam int CBI_CYC_OWN_BIT   = 1;
  localparam int CBI_CYC_ABORT_BIT = 2;

  // Processor status register fields
  localparam int CBI_PST_FLAG_LSB = 0;  // Flags 0..2
  localparam int CBI_PST_IE_BIT   = 3;
  localparam int CBI_PST_SA_BIT   = 4;
  localparam int CBI_PST_SB_BIT   = 5;

  // Reset values
  localparam logic [15:0] CBI_ADDR_RST  = 16'h0000;
  localparam logic [7:0]  CBI_BYTE_RST  = 8'h00;
  localparam logic [2:0]  CBI_FLAG_RST  = 3'h0;

  // Bus-cycle timing in SYS_CLK cycles
  localparam logic [3:0] CBI_ADS_CYCLES    = 4'h2; // Address strobe low
  localparam logic [3:0] CBI_SETUP_CYCLES  = 4'h1; // Gap before data strobe
  localparam logic [3:0] CBI_STROBE_CYCLES = 4'h3; // Least data strobe width

  typedef enum logic [2:0] {
    CBI_ST_IDLE,
    CBI_ST_ADS,
    CBI_ST_SETUP,
    CBI_ST_STROBE,
    CBI_ST_TAIL
  } cbi_state_t;

endpackage

// ==== src/cbi_shift_reg.sv ====
// Extension register with serial shift: load from software, right shift
// with the serial input entering at the top, latched serial output.
// Assumes load and shift are one-cycle pulses in the SYS_CLK domain.
`timescale 1ns/1ps
module cbi_shift_reg #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load_en,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             shift_en,
  input  wire logic             ser_in,
  output logic      [WIDTH-1:0] value,
  output logic                  ser_out
);

  logic [WIDTH-1:0] ext_r;
  logic [WIDTH-1:0] ext_nxt;
  logic             ser_out_r;
  logic             ser_out_nxt;

  // Load wins over a shift in the same cycle, software intent is newer
  always_comb begin
    ext_nxt     = ext_r;
    ser_out_nxt = ser_out_r;
    if (load_en) begin
      ext_nxt = load_val;
    end else if (shift_en) begin
      ext_nxt     = {ser_in, ext_r[WIDTH-1:1]};
      ser_out_nxt = ext_r[0];
    end
  end

  // Output bit stays latched between shifts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_r  <= '0;
      ser_out_r <= 1'b0;
    end else begin
      ext_r  <= ext_nxt;
      ser_out_r <= ser_out_nxt;
    end
  end

  assign value   = ext_r;
  assign ser_out = ser_out_r;

endmodule // cbi_shift_reg

// ==== src/cbi_top.sv ====
// Top of the CPU system bus interface: APB register slave, bus cycle
// sequencer with grant chain, strobes, cycle extension, sense, flags, serial.
// Assumes all pin inputs are synchronous to SYS_CLK; floating wires are
// resolved outside from the _OE outputs.
`timescale 1ns/1ps
module cbi_top #(
  parameter int AW = 8
) (
  input  wire logic          SYS_CLK,
  input  wire logic          RST,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          BUS_GRANT_IN,
  output logic               BUS_GRANT_OUT,
  output logic               ADDR_STATUS_STROBE_N,
  output logic               READ_STROBE_N,
  output logic               READ_STROBE_OE,
  output logic               WRITE_STROBE_N,
  output logic               WRITE_STROBE_OE,
  input  wire logic          CYCLE_EXTEND_N,
  input  wire logic [7:0]    DATA_IN,
  output logic      [7:0]    DATA_OUT,
  output logic               DATA_OE,
  output logic      [11:0]   LOW_ADDRESS_LINES,
  output logic               LOW_ADDRESS_OE,
  input  wire logic          SENSE_A,
  input  wire logic          SENSE_B,
  output logic               INT_REQ,
  input  wire logic          SERIAL_IN_LINE,
  output logic               SERIAL_OUT_LINE,
  output logic      [2:0]    FLAG_OUT
);

  cbi_pkg::cbi_state_t state_r;
  cbi_pkg::cbi_state_t state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic        pend_r;
  logic        pend_nxt;
  logic        is_read_r;
  logic        is_read_nxt;
  logic [2:0]  cmd_ext_r;
  logic [2:0]  cmd_ext_nxt;
  logic        abort_r;
  logic        abort_nxt;
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic [7:0]  wdata_r;
  logic [7:0]  wdata_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic [2:0]  flag_r;
  logic [2:0]  flag_nxt;
  logic        ie_r;
  logic        ie_nxt;
  logic        sense_a_r;
  logic        sense_b_r;
  logic        irq_r;
  logic        irq_nxt;
  logic        gout_r;
  logic        gout_nxt;
  logic        ads_n_r;
  logic        ads_n_nxt;
  logic        rd_n_r;
  logic        rd_n_nxt;
  logic        wr_n_r;
  logic        wr_n_nxt;
  logic        own_r;
  logic        own_nxt;
  logic [7:0]  dout_r;
  logic [7:0]  dout_nxt;
  logic        doe_r;
  logic        doe_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        apb_setup;
  logic        apb_wr;
  logic        busy;
  logic        start_cmd;
  logic        ext_load;
  logic        ext_shift;
  logic [7:0]  ext_val;
  logic        ser_out_bit;
  logic [31:0] rd_word;
  logic        mapped;

  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr    = PSEL && PENABLE && pready_r && PWRITE;
  assign busy      = pend_r || (state_r != cbi_pkg::CBI_ST_IDLE);
  assign start_cmd = apb_wr && (PADDR == AW'(cbi_pkg::CBI_OFS_CMD)) &&
                     PWDATA[cbi_pkg::CBI_CMD_GO_BIT] && !busy;
  assign ext_load  = apb_wr && (PADDR == AW'(cbi_pkg::CBI_OFS_EXT));
  assign ext_shift = apb_wr && (PADDR == AW'(cbi_pkg::CBI_OFS_SHIFT));

  // Extension register and serial line
  cbi_shift_reg #(
    .WIDTH (8)
  ) u_ext (
    .clk      (SYS_CLK),
    .rst      (RST),
    .load_en  (ext_load),
    .load_val (PWDATA[7:0]),
    .shift_en (ext_shift),
    .ser_in   (SERIAL_IN_LINE),
    .value    (ext_val),
    .ser_out  (ser_out_bit)
  );

  // Read mux; unmapped offsets read zero and raise PSLVERR
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    case (PADDR)
      AW'(cbi_pkg::CBI_OFS_ADDR):  rd_word[15:0] = addr_r;
      AW'(cbi_pkg::CBI_OFS_WDATA): rd_word[7:0]  = wdata_r;
      AW'(cbi_pkg::CBI_OFS_CMD): begin
        rd_word[cbi_pkg::CBI_CMD_READ_BIT] = is_read_r;
        rd_word[cbi_pkg::CBI_CMD_EXT_LSB +: 3] = cmd_ext_r;
      end
      AW'(cbi_pkg::CBI_OFS_CYC): begin
        rd_word[cbi_pkg::CBI_CYC_BUSY_BIT]  = busy;
        rd_word[cbi_pkg::CBI_CYC_OWN_BIT]   = own_r;
        rd_word[cbi_pkg::CBI_CYC_ABORT_BIT] = abort_r;
      end
      AW'(cbi_pkg::CBI_OFS_PSTAT): begin
        rd_word[cbi_pkg::CBI_PST_FLAG_LSB +: 3] = flag_r;
        rd_word[cbi_pkg::CBI_PST_IE_BIT] = ie_r;
        rd_word[cbi_pkg::CBI_PST_SA_BIT] = sense_a_r;
        rd_word[cbi_pkg::CBI_PST_SB_BIT] = sense_b_r;
      end
      AW'(cbi_pkg::CBI_OFS_RDATA): rd_word[7:0] = rdata_r;
      AW'(cbi_pkg::CBI_OFS_EXT):   rd_word[7:0] = ext_val;
      AW'(cbi_pkg::CBI_OFS_SHIFT): rd_word = 32'h0000_0000;
      default:                     mapped  = 1'b0;
    endcase
  end

  // APB answer: one wait-free access, data prepared in the setup cycle
  always_comb begin
    pready_nxt  = apb_setup;
    prdata_nxt  = apb_setup ? rd_word : 32'h0000_0000;
    pslverr_nxt = apb_setup && !mapped;
  end

  // Software-visible configuration; address and data frozen while busy
  // so the pins stay stable through a whole cycle
  always_comb begin
    addr_nxt    = addr_r;
    wdata_nxt   = wdata_r;
    is_read_nxt = is_read_r;
    cmd_ext_nxt = cmd_ext_r;
    flag_nxt    = flag_r;
    ie_nxt      = ie_r;
    if (apb_wr && !busy && (PADDR == AW'(cbi_pkg::CBI_OFS_ADDR))) begin
      addr_nxt = PWDATA[15:0];
    end
    if (apb_wr && !busy && (PADDR == AW'(cbi_pkg::CBI_OFS_WDATA))) begin
      wdata_nxt = PWDATA[7:0];
    end
    if (start_cmd) begin
      is_read_nxt = PWDATA[cbi_pkg::CBI_CMD_READ_BIT];
      cmd_ext_nxt = PWDATA[cbi_pkg::CBI_CMD_EXT_LSB +: 3];
    end
    if (apb_wr && (PADDR == AW'(cbi_pkg::CBI_OFS_PSTAT))) begin
      flag_nxt = PWDATA[cbi_pkg::CBI_PST_FLAG_LSB +: 3];
      ie_nxt   = PWDATA[cbi_pkg::CBI_PST_IE_BIT];
    end
    irq_nxt = ie_r && sense_a_r;
  end

  // Cycle sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    pend_nxt  = pend_r;
    rdata_nxt = rdata_r;
    abort_nxt = abort_r;
    if (start_cmd) begin
      pend_nxt  = 1'b1;
      abort_nxt = 1'b0;
    end
    case (state_r)
      cbi_pkg::CBI_ST_IDLE: begin
        if (pend_r && BUS_GRANT_IN) begin
          state_nxt = cbi_pkg::CBI_ST_ADS;
          cnt_nxt   = cbi_pkg::CBI_ADS_CYCLES - 4'h1;
          pend_nxt  = 1'b0;
        end
      end
      cbi_pkg::CBI_ST_ADS: begin
        if (cnt_r == 4'h0) begin
          state_nxt = cbi_pkg::CBI_ST_SETUP;
          cnt_nxt   = cbi_pkg::CBI_SETUP_CYCLES - 4'h1;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      cbi_pkg::CBI_ST_SETUP: begin
        if (cnt_r == 4'h0) begin
          state_nxt = cbi_pkg::CBI_ST_STROBE;
          cnt_nxt   = cbi_pkg::CBI_STROBE_CYCLES - 4'h1;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      cbi_pkg::CBI_ST_STROBE: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (CYCLE_EXTEND_N) begin
          state_nxt = cbi_pkg::CBI_ST_TAIL;
          if (is_read_r) begin
            rdata_nxt = DATA_IN;
          end
        end
      end
      cbi_pkg::CBI_ST_TAIL: state_nxt = cbi_pkg::CBI_ST_IDLE;
      default:              state_nxt = cbi_pkg::CBI_ST_IDLE;
    endcase
    // Losing the grant ends the cycle at once; the abort flag records it
    // and beats a clearing start in the same cycle
    if (!BUS_GRANT_IN && (state_r != cbi_pkg::CBI_ST_IDLE)) begin
      state_nxt = cbi_pkg::CBI_ST_IDLE;
      abort_nxt = 1'b1;
    end
  end

  // Pin values are derived from the next state so they leave flip-flops
  // aligned with the state itself
  always_comb begin
    own_nxt   = (state_nxt != cbi_pkg::CBI_ST_IDLE);
    gout_nxt  = BUS_GRANT_IN && !own_nxt;
    ads_n_nxt = !(state_nxt == cbi_pkg::CBI_ST_ADS);
    rd_n_nxt  = !((state_nxt == cbi_pkg::CBI_ST_STROBE) && is_read_r);
    wr_n_nxt  = !((state_nxt == cbi_pkg::CBI_ST_STROBE) && !is_read_r);
    doe_nxt   = (state_nxt == cbi_pkg::CBI_ST_ADS) ||
                ((state_nxt == cbi_pkg::CBI_ST_STROBE) && !is_read_r);
    if (state_nxt == cbi_pkg::CBI_ST_ADS) begin
      dout_nxt = {cmd_ext_r, is_read_r, addr_r[15:12]};
    end else if (doe_nxt) begin
      dout_nxt = wdata_r;
    end else begin
      dout_nxt = 8'h00;
    end
  end

  // Registers of the whole block except the extension register in u_ext
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_r   <= cbi_pkg::CBI_ST_IDLE;
      cnt_r     <= 4'h0;
      pend_r    <= 1'b0;
      is_read_r <= 1'b0;
      cmd_ext_r <= 3'h0;
      abort_r   <= 1'b0;
      addr_r    <= cbi_pkg::CBI_ADDR_RST;
      wdata_r   <= cbi_pkg::CBI_BYTE_RST;
      rdata_r   <= cbi_pkg::CBI_BYTE_RST;
      flag_r    <= cbi_pkg::CBI_FLAG_RST;
      ie_r      <= 1'b0;
      sense_a_r <= 1'b0;
      sense_b_r <= 1'b0;
      irq_r     <= 1'b0;
      gout_r    <= 1'b0;
      ads_n_r   <= 1'b1;
      rd_n_r    <= 1'b1;
      wr_n_r    <= 1'b1;
      own_r     <= 1'b0;
      dout_r    <= 8'h00;
      doe_r     <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      pend_r    <= pend_nxt;
      is_read_r <= is_read_nxt;
      cmd_ext_r <= cmd_ext_nxt;
      abort_r   <= abort_nxt;
      addr_r    <= addr_nxt;
      wdata_r   <= wdata_nxt;
      rdata_r   <= rdata_nxt;
      flag_r    <= flag_nxt;
      ie_r      <= ie_nxt;
      sense_a_r <= SENSE_A;
      sense_b_r <= SENSE_B;
      irq_r     <= irq_nxt;
      gout_r    <= gout_nxt;
      ads_n_r   <= ads_n_nxt;
      rd_n_r    <= rd_n_nxt;
      wr_n_r    <= wr_n_nxt;
      own_r     <= own_nxt;
      dout_r    <= dout_nxt;
      doe_r     <= doe_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Ports; data strobes and address float with ownership
  assign PRDATA               = prdata_r;
  assign PREADY               = pready_r;
  assign PSLVERR              = pslverr_r;
  assign BUS_GRANT_OUT        = gout_r;
  assign ADDR_STATUS_STROBE_N = ads_n_r;
  assign READ_STROBE_N        = rd_n_r;
  assign READ_STROBE_OE       = own_r;
  assign WRITE_STROBE_N       = wr_n_r;
  assign WRITE_STROBE_OE      = own_r;
  assign DATA_OUT             = dout_r;
  assign DATA_OE              = doe_r;
  assign LOW_ADDRESS_LINES    = addr_r[11:0];
  assign LOW_ADDRESS_OE       = own_r;
  assign INT_REQ              = irq_r;
  assign SERIAL_OUT_LINE      = ser_out_bit;
  assign FLAG_OUT             = flag_r;

endmodule // cbi_top

// ==== bench/cbi_bus_model.sv ====
// Bus partner model: peripheral on the shared bus, answering read and write strobes.
// Assumes strobe levels are already resolved from their enables (pulled high).
`timescale 1ns/1ps
module cbi_bus_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        ads_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  dout,
  input  wire logic        doe,
  input  wire logic [11:0] addr,
  output logic      [7:0]  din,
  output logic             ext_n,
  output logic      [7:0]  stat_b,
  output logic      [7:0]  wr_b,
  output logic      [11:0] wr_a
);
  logic [7:0] last_r = 8'h00;
  logic [3:0] cnt_r  = 4'h0;
  // Data only while read strobe is low; else inverse of last value, so a
  // released bus toggles each cycle between the old data and its inverse
  assign din   = !rd_n ? (addr[7:0] ^ 8'h5A) : ~last_r;
  // Slow mode holds the cycle for the first six strobe cycles
  assign ext_n = !(slow && (!rd_n || !wr_n) && cnt_r < 4'h6);
  // Capture status and write data as a peripheral would
  always_ff @(posedge clk) begin
    last_r <= din;
    cnt_r  <= (rd_n && wr_n) ? 4'h0 : cnt_r + 4'h1;
    if (!ads_n && doe) stat_b <= dout;
    if (!wr_n && doe) begin
      wr_b <= dout;
      wr_a <= addr;
    end
  end
endmodule // cbi_bus_model

// ==== bench/cbi_top_asserts.sv ====
// Checker of the bus pins: grant chain, float, strobe order and widths.
// Assumes it is bound into cbi_top; one clock, async reset active high.
`timescale 1ns/1ps
module cbi_top_asserts (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        BUS_GRANT_IN,
  input wire logic        BUS_GRANT_OUT,
  input wire logic        ADDR_STATUS_STROBE_N,
  input wire logic        READ_STROBE_N,
  input wire logic        READ_STROBE_OE,
  input wire logic        WRITE_STROBE_N,
  input wire logic        WRITE_STROBE_OE,
  input wire logic        CYCLE_EXTEND_N,
  input wire logic [7:0]  DATA_OUT,
  input wire logic        DATA_OE,
  input wire logic [11:0] LOW_ADDRESS_LINES,
  input wire logic        LOW_ADDRESS_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Either data strobe low
  wire act = !READ_STROBE_N || !WRITE_STROBE_N;
  a_grant_chain: assert property (
    !$past(RST) |-> BUS_GRANT_OUT == ($past(BUS_GRANT_IN) && !LOW_ADDRESS_OE))
    else $error("grant out wrong");
  a_owned_grant: assert property (LOW_ADDRESS_OE |-> $past(BUS_GRANT_IN))
    else $error("bus held without grant");
  a_float_lines: assert property (
    !LOW_ADDRESS_OE |-> !READ_STROBE_OE && !WRITE_STROBE_OE && !DATA_OE)
    else $error("line driven while not owned");
  a_ads_width: assert property ($fell(ADDR_STATUS_STROBE_N) |=>
    !ADDR_STATUS_STROBE_N ##1 ADDR_STATUS_STROBE_N) else $error("address strobe width");
  a_ads_status: assert property (
    !ADDR_STATUS_STROBE_N |-> DATA_OE && LOW_ADDRESS_OE) else $error("status not driven");
  a_cycle_dir: assert property ($rose(ADDR_STATUS_STROBE_N) && LOW_ADDRESS_OE |=>
    act && WRITE_STROBE_N == $past(DATA_OUT[4], 2)) else $error("strobe mismatches flag");
  a_strobe_min: assert property ($rose(act) |-> act [*3])
    else $error("strobe too short");
  a_extend_hold: assert property (
    act && $past(act, 2) && !CYCLE_EXTEND_N && BUS_GRANT_IN |=> act)
    else $error("strobe ended during extend");
  a_extend_end: assert property (
    act && $past(act, 2) && CYCLE_EXTEND_N && BUS_GRANT_IN |=> !act)
    else $error("strobe not released");
  a_addr_stable: assert property (
    LOW_ADDRESS_OE && $past(LOW_ADDRESS_OE) |-> $stable(LOW_ADDRESS_LINES))
    else $error("address moved in cycle");
  a_wdata_valid: assert property (!WRITE_STROBE_N |->
    DATA_OE && ($past(WRITE_STROBE_N) || $stable(DATA_OUT))) else $error("write data lost");
  a_data_release: assert property (
    DATA_OE |-> !ADDR_STATUS_STROBE_N || !WRITE_STROBE_N) else $error("data bus not released");
  c_read: cover property ($rose(act) && !READ_STROBE_N);
  c_extend: cover property (!WRITE_STROBE_N && !CYCLE_EXTEND_N);
  c_abort: cover property (LOW_ADDRESS_OE && !BUS_GRANT_IN);
endmodule // cbi_top_asserts

bind cbi_top cbi_top_asserts i_cbi_top_asserts (
  .SYS_CLK(SYS_CLK), .RST(RST), .BUS_GRANT_IN(BUS_GRANT_IN), .BUS_GRANT_OUT(BUS_GRANT_OUT),
  .ADDR_STATUS_STROBE_N(ADDR_STATUS_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
  .READ_STROBE_OE(READ_STROBE_OE), .WRITE_STROBE_N(WRITE_STROBE_N),
  .WRITE_STROBE_OE(WRITE_STROBE_OE), .CYCLE_EXTEND_N(CYCLE_EXTEND_N), .DATA_OUT(DATA_OUT),
  .DATA_OE(DATA_OE), .LOW_ADDRESS_LINES(LOW_ADDRESS_LINES), .LOW_ADDRESS_OE(LOW_ADDRESS_OE));

// ==== bench/test_cbi_top.sv ====
// Self-checking bench: APB accesses and bus cycles against the bus model.
// Assumes cbi_top with its checker bound, peripheral model on the bus pins.
`timescale 1ns/1ps
module test_cbi_top;
  logic        SYS_CLK, RST, PSEL, PENABLE, PWRITE, BUS_GRANT_IN, err, si, ob;
  logic        SENSE_A, SENSE_B, SERIAL_IN_LINE, slow, PREADY, PSLVERR, INT_REQ;
  logic        BUS_GRANT_OUT, ADDR_STATUS_STROBE_N, SERIAL_OUT_LINE, CYCLE_EXTEND_N;
  logic        READ_STROBE_N, READ_STROBE_OE, WRITE_STROBE_N, WRITE_STROBE_OE;
  logic        DATA_OE, LOW_ADDRESS_OE;
  logic [7:0]  PADDR, DATA_IN, DATA_OUT, stat_b, wr_b, e;
  logic [31:0] PWDATA, PRDATA, q;
  logic [11:0] LOW_ADDRESS_LINES, wr_a;
  logic [2:0]  FLAG_OUT;
  int          errors = 0, n_tests = 0, cyc = 0, i;

  cbi_top i_cbi_top (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .BUS_GRANT_IN(BUS_GRANT_IN), .BUS_GRANT_OUT(BUS_GRANT_OUT),
    .ADDR_STATUS_STROBE_N(ADDR_STATUS_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
    .READ_STROBE_OE(READ_STROBE_OE), .WRITE_STROBE_N(WRITE_STROBE_N),
    .WRITE_STROBE_OE(WRITE_STROBE_OE), .CYCLE_EXTEND_N(CYCLE_EXTEND_N), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .LOW_ADDRESS_LINES(LOW_ADDRESS_LINES),
    .LOW_ADDRESS_OE(LOW_ADDRESS_OE), .SENSE_A(SENSE_A), .SENSE_B(SENSE_B), .INT_REQ(INT_REQ),
    .SERIAL_IN_LINE(SERIAL_IN_LINE), .SERIAL_OUT_LINE(SERIAL_OUT_LINE), .FLAG_OUT(FLAG_OUT));
  // Undriven strobes float up to their idle level
  cbi_bus_model i_cbi_bus_model (.clk(SYS_CLK), .slow(slow), .ads_n(ADDR_STATUS_STROBE_N),
    .rd_n(READ_STROBE_OE ? READ_STROBE_N : 1'b1), .wr_n(WRITE_STROBE_OE ? WRITE_STROBE_N : 1'b1),
    .dout(DATA_OUT), .doe(DATA_OE), .addr(LOW_ADDRESS_LINES), .din(DATA_IN),
    .ext_n(CYCLE_EXTEND_N), .stat_b(stat_b), .wr_b(wr_b), .wr_a(wr_a));

  // 100 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // Timeout well above the few hundred cycles the sequence needs
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic cmd(input logic [15:0] a, input logic [7:0] d, input logic [4:0] c);
    apb(1'b1, cbi_pkg::CBI_OFS_ADDR, {16'h0000, a});
    apb(1'b1, cbi_pkg::CBI_OFS_WDATA, {24'h00_0000, d});
    apb(1'b1, cbi_pkg::CBI_OFS_CMD, {27'h000_0000, c});
  endtask
  // Poll the busy bit a bounded number of times
  task automatic wait_idle();
    for (int k = 0; k < 40; k++) begin
      apb(1'b0, cbi_pkg::CBI_OFS_CYC, 32'h0000_0000);
      if (q[0] === 1'b0) break;
    end
    chk(32'(q[0]), 32'h0000_0000);
  endtask

  initial begin
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, SENSE_A, SERIAL_IN_LINE, slow} = 6'h00;
    {SENSE_B, BUS_GRANT_IN} = 2'h3;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    apb(1'b0, cbi_pkg::CBI_OFS_PSTAT, 32'h0000_0000);
    chk(q, 32'h0000_0020);
    chk(32'(BUS_GRANT_OUT), 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({q[30:0], err}, 32'h0000_0001);
    // Write then fast read, then read held by the slow peripheral
    cmd(16'h5ABC, 8'h3C, 5'h15);
    wait_idle();
    chk(32'(stat_b), 32'h0000_00A5);
    chk(32'(wr_b), 32'h0000_003C);
    chk(32'(wr_a), 32'h0000_0ABC);
    cmd(16'h9123, 8'h00, 5'h03);
    wait_idle();
    chk(32'(stat_b), 32'h0000_0019);
    apb(1'b0, cbi_pkg::CBI_OFS_RDATA, 32'h0000_0000);
    chk(q, 32'h0000_0079);
    slow <= 1'b1;
    cmd(16'h0FF0, 8'h00, 5'h03);
    wait_idle();
    apb(1'b0, cbi_pkg::CBI_OFS_RDATA, 32'h0000_0000);
    chk(q, 32'h0000_00AA);
    // Grant withdrawn in mid strobe aborts the cycle
    cmd(16'h1234, 8'h55, 5'h01);
    for (i = 0; i < 40 && WRITE_STROBE_N !== 1'b0; i++) @(posedge SYS_CLK);
    repeat (3) @(posedge SYS_CLK);
    BUS_GRANT_IN <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    chk(32'({READ_STROBE_OE, WRITE_STROBE_OE, DATA_OE, LOW_ADDRESS_OE}), 32'h0);
    apb(1'b0, cbi_pkg::CBI_OFS_CYC, 32'h0000_0000);
    chk(q, 32'h0000_0004);
    // Cycle commanded while denied waits for grant
    cmd(16'h2000, 8'h77, 5'h01);
    repeat (8) @(posedge SYS_CLK);
    chk(32'({ADDR_STATUS_STROBE_N, LOW_ADDRESS_OE, BUS_GRANT_OUT}), 32'h4);
    apb(1'b0, cbi_pkg::CBI_OFS_CYC, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    // Address write while a cycle is pending must be ignored
    apb(1'b1, cbi_pkg::CBI_OFS_ADDR, 32'h0000_FFFF);
    apb(1'b0, cbi_pkg::CBI_OFS_ADDR, 32'h0000_0000);
    chk(q, 32'h0000_2000);
    BUS_GRANT_IN <= 1'b1;
    wait_idle();
    chk(32'(wr_b), 32'h0000_0077);
    chk(32'(wr_a), 32'h0000_0000);
    // Sense inputs, interrupt request and flags
    SENSE_A <= 1'b1;
    SENSE_B <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    apb(1'b0, cbi_pkg::CBI_OFS_PSTAT, 32'h0000_0000);
    chk(q, 32'h0000_0010);
    chk(32'(INT_REQ), 32'h0);
    apb(1'b1, cbi_pkg::CBI_OFS_PSTAT, 32'h0000_000E);
    repeat (2) @(posedge SYS_CLK);
    chk(32'(INT_REQ), 32'h1);
    chk(32'(FLAG_OUT), 32'h6);
    SENSE_A <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    chk(32'(INT_REQ), 32'h0);
    // Serial shifts, output latched between shifts
    apb(1'b1, cbi_pkg::CBI_OFS_EXT, 32'h0000_00B4);
    e = 8'hB4;
    for (i = 0; i < 3; i++) begin
      si = (i != 1);
      SERIAL_IN_LINE <= si;
      apb(1'b1, cbi_pkg::CBI_OFS_SHIFT, 32'h0000_0000);
      @(posedge SYS_CLK);
      ob = e[0];
      chk(32'(SERIAL_OUT_LINE), 32'(ob));
      e = {si, e[7:1]};
    end
    SERIAL_IN_LINE <= ~si;
    repeat (5) @(posedge SYS_CLK);
    chk(32'(SERIAL_OUT_LINE), 32'(ob));
    apb(1'b0, cbi_pkg::CBI_OFS_EXT, 32'h0000_0000);
    chk(q, 32'(e));
    test_done();
  end
endmodule // test_cbi_top
